// ==== dv/usart_status_write_protect_tb.sv ====
// Self-checking bench for the status and write protect block
`timescale 1ns/1ps
`include "usw_regs.svh"
`default_nettype none
module usart_status_write_protect_tb;
  logic                clk = 1'b0;
  logic                rst;
  logic [7:0]          awaddr, araddr;
  logic [31:0]         wdata, rdata;
  logic [3:0]          wstrb, dly;
  logic [1:0]          bresp, rresp;
  logic                awvalid, awready, wvalid, wready, bvalid, bready;
  logic                arvalid, arready, rvalid, rready, viol, irq, prot;
  usw_pkg::usw_modem_s lvl, modem;
  int                  mismatches = 0;
  int                  cmp_count = 0;
  int                  cycles = 0;
  logic [7:0]          cfg_off [7] = '{`USW_OFF_MODE, `USW_OFF_BAUD, `USW_OFF_RX_TIMEOUT,
    `USW_OFF_TX_GUARD, `USW_OFF_FIDI, `USW_OFF_IR_FILTER, `USW_OFF_MAN_CONFIG};
  logic [31:0]         cfg_out [7];
  usw_top i_dut (.i_clk_sys(clk), .i_reset(rst), .i_s_axi_awaddr(awaddr),
    .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready), .i_s_axi_wdata(wdata),
    .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready),
    .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
    .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
    .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
    .i_s_axi_rready(rready), .i_modem(modem), .i_manchester_violation(viol), .o_irq(irq),
    .o_protect_active(prot), .o_mode(cfg_out[0]), .o_baud(cfg_out[1]),
    .o_rx_timeout(cfg_out[2]), .o_tx_guard(cfg_out[3]), .o_fidi(cfg_out[4]),
    .o_ir_filter(cfg_out[5]), .o_man_config(cfg_out[6]));
  usw_modem_model i_model (.i_clk_sys(clk), .i_level(lvl), .i_delay(dly), .o_modem(modem));
  always #10 clk = ~clk;
  // ********
  // Tasks
  // ********
  task automatic finish_test();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  // Address and data offered together; each dropped once taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk("bresp", 32'(r), 32'(bresp));
    @(posedge clk);
  endtask
  // Extra idle edge at the end keeps ready from toggling twice in a step
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk("rdata", e, rdata);
    chk("rresp", 32'(r), 32'(rresp));
    @(posedge clk);
  endtask
  // Waits out model delay, two sync stages and the flag stage
  task automatic pins(input logic [3:0] v, input logic [3:0] d);
    lvl <= v;
    dly <= d;
    repeat (int'(d) + 6) @(posedge clk);
  endtask
  task automatic cfg_pass(input logic [31:0] wb, input logic [31:0] eb);
    for (int i = 0; i < 7; i++) begin
      axw(cfg_off[i], wb + 32'(i), 4'hf, `USW_OKAY);
      rdc(cfg_off[i], eb + 32'(i), `USW_OKAY);
      chk("cfg_out", eb + 32'(i), cfg_out[i]);
    end
  endtask
  function automatic logic [31:0] st(input logic [3:0] m, input logic c, input logic e);
    st = {7'h00, e, m[0], m[1], m[2], m[3], c, 19'h0_0000};
  endfunction
  // Hang guard, well above the few hundred cycles needed
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      finish_test();
    end
  end
  // ********
  // Sequence
  // ********
  initial begin
    rst = 1'b1;
    {awaddr, araddr, wstrb, dly} = 24'h00_0000;
    wdata = 32'h0000_0000;
    lvl = '0;
    {awvalid, wvalid, bready, arvalid, rready, viol} = 6'h00;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdc(`USW_OFF_WPROT, 32'h0000_0000, `USW_OKAY);
    rdc(`USW_OFF_CHAN_STATUS, 32'h0000_0000, `USW_OKAY);
    for (int i = 0; i < 3; i++) begin
      pins(4'h8 >> i, 4'(2 * i));
      rdc(`USW_OFF_CHAN_STATUS, st(4'h8 >> i, 1'b0, 1'b0), `USW_OKAY);
    end
    pins(4'h1, 4'h0);
    rdc(`USW_OFF_CHAN_STATUS, st(4'h1, 1'b1, 1'b0), `USW_OKAY);
    rdc(`USW_OFF_CHAN_STATUS, st(4'h1, 1'b0, 1'b0), `USW_OKAY);
    pins(4'h0, 4'h5);
    rdc(`USW_OFF_CHAN_STATUS, st(4'h0, 1'b1, 1'b0), `USW_OKAY);
    axw(`USW_OFF_IRQ_MASK, 32'h0100_0000, 4'hf, `USW_OKAY);
    viol <= 1'b1;
    @(posedge clk);
    viol <= 1'b0;
    rdc(`USW_OFF_CHAN_STATUS, st(4'h0, 1'b0, 1'b1), `USW_OKAY);
    chk("irq", 32'h0000_0001, 32'(irq));
    axw(`USW_OFF_IRQ_MASK, 32'h0000_0000, 4'hf, `USW_OKAY);
    chk("irq", 32'h0000_0000, 32'(irq));
    rdc(`USW_OFF_CHAN_STATUS, st(4'h0, 1'b0, 1'b1), `USW_OKAY);
    axw(`USW_OFF_CONTROL, 32'h0000_0100, 4'hf, `USW_OKAY);
    rdc(`USW_OFF_CHAN_STATUS, st(4'h0, 1'b0, 1'b0), `USW_OKAY);
    axw(`USW_OFF_IRQ_MASK, 32'h0100_0000, 4'hf, `USW_OKAY);
    chk("irq", 32'h0000_0000, 32'(irq));
    cfg_pass(32'ha5a5_0000, 32'ha5a5_0000);
    axw(`USW_OFF_WPROT, {`USW_PROTECT_KEY, 8'h01}, 4'hf, `USW_OKAY);
    chk("protect", 32'h0000_0001, 32'(prot));
    rdc(`USW_OFF_WPROT, 32'h0000_0001, `USW_OKAY);
    cfg_pass(32'h5a5a_0000, 32'ha5a5_0000);
    axw(`USW_OFF_WPROT, {24'h55_5340, 8'h00}, 4'hf, `USW_OKAY);
    axw(`USW_OFF_WPROT, {`USW_PROTECT_KEY, 8'h00}, 4'h1, `USW_OKAY);
    chk("protect", 32'h0000_0001, 32'(prot));
    axw(`USW_OFF_WPROT, {`USW_PROTECT_KEY, 8'h00}, 4'hf, `USW_OKAY);
    chk("protect", 32'h0000_0000, 32'(prot));
    axw(`USW_OFF_WPROT, 32'h0000_0001, 4'hf, `USW_OKAY);
    chk("protect", 32'h0000_0000, 32'(prot));
    cfg_pass(32'h5a5a_0000, 32'h5a5a_0000);
    axw(8'h80, 32'h0000_0001, 4'hf, `USW_SLVERR);
    rdc(8'h80, 32'h0000_0000, `USW_SLVERR);
    finish_test();
  end
endmodule
`default_nettype wire

// ==== dv/usw_modem_model.sv ====
// Far-side model: remote equipment driving the modem control lines
`timescale 1ns/1ps
`default_nettype none
module usw_modem_model (
  input  wire logic                i_clk_sys,
  input  wire usw_pkg::usw_modem_s i_level,
  input  wire logic [3:0]          i_delay,
  output var usw_pkg::usw_modem_s  o_modem
);
  usw_pkg::usw_modem_s pend     = '0;
  logic [3:0]          wait_cnt = 4'h0;
  initial o_modem = '0;
  // Remote side answers after a chosen delay, off the clock edge
  always @(posedge i_clk_sys) begin
    if (i_level != pend) begin
      pend <= i_level;
      wait_cnt <= i_delay;
    end else if (wait_cnt != 4'h0) begin
      wait_cnt <= wait_cnt - 4'h1;
    end else begin
      o_modem <= #7 pend;
    end
  end
endmodule
`default_nettype wire

// ==== dv/usw_top_checker.sv ====
// Concurrent checks on the status and write protect block ports
`timescale 1ns/1ps
`include "usw_regs.svh"
`default_nettype none
module usw_top_checker (
  input wire logic                i_clk_sys,
  input wire logic                i_reset,
  input wire logic [7:0]          i_s_axi_awaddr,
  input wire logic                i_s_axi_awvalid,
  input wire logic                o_s_axi_awready,
  input wire logic [31:0]         i_s_axi_wdata,
  input wire logic [3:0]          i_s_axi_wstrb,
  input wire logic                i_s_axi_wvalid,
  input wire logic                o_s_axi_wready,
  input wire logic [7:0]          i_s_axi_araddr,
  input wire logic                i_s_axi_arvalid,
  input wire logic                o_s_axi_arready,
  input wire logic [31:0]         o_s_axi_rdata,
  input wire usw_pkg::usw_modem_s i_modem,
  input wire logic                i_manchester_violation,
  input wire logic                o_protect_active,
  input wire logic [31:0]         o_mode,
  input wire logic [31:0]         o_baud,
  input wire logic [31:0]         o_rx_timeout,
  input wire logic [31:0]         o_tx_guard,
  input wire logic [31:0]         o_fidi,
  input wire logic [31:0]         o_ir_filter,
  input wire logic [31:0]         o_man_config
);
  // ********
  // Decode
  // ********
  logic         wr_take;
  logic         st_read;
  logic         wp_ok;
  logic [223:0] cfg_all;
  // Only writes with both halves taken together are judged
  assign wr_take = i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready;
  assign st_read = i_s_axi_arvalid && o_s_axi_arready && i_s_axi_araddr == `USW_OFF_CHAN_STATUS;
  assign wp_ok   = wr_take && i_s_axi_awaddr == `USW_OFF_WPROT && i_s_axi_wstrb == 4'hf
                   && i_s_axi_wdata[31:8] == `USW_PROTECT_KEY;
  assign cfg_all = {o_mode, o_baud, o_rx_timeout, o_tx_guard, o_fidi, o_ir_filter, o_man_config};
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  property p_modem_image;
    $stable(i_modem) [*4] ##0 st_read ##1 $stable(i_modem) |->
      o_s_axi_rdata[23:20] == {i_modem.cts, i_modem.dcd, i_modem.dsr, i_modem.ri};
  endproperty
  a_modem_image: assert property (p_modem_image) else $error("modem image wrong");
  property p_cts_flag;
    $changed(i_modem.cts) ##1 (!st_read) [*3] ##1 st_read |=> o_s_axi_rdata[19];
  endproperty
  a_cts_flag: assert property (p_cts_flag) else $error("cts change flag missing");
  property p_man_flag;
    (i_manchester_violation && !i_s_axi_wvalid) ##1 (st_read && !i_s_axi_wvalid)
      |=> o_s_axi_rdata[24];
  endproperty
  a_man_flag: assert property (p_man_flag) else $error("manchester flag missing");
  property p_prot_on;
    wp_ok && i_s_axi_wdata[0] |-> ##2 o_protect_active;
  endproperty
  a_prot_on: assert property (p_prot_on) else $error("protect not enabled");
  property p_prot_off;
    wp_ok && !i_s_axi_wdata[0] |-> ##2 !o_protect_active;
  endproperty
  a_prot_off: assert property (p_prot_off) else $error("protect not disabled");
  property p_bad_key;
    wr_take && i_s_axi_awaddr == `USW_OFF_WPROT && i_s_axi_wdata[31:8] != `USW_PROTECT_KEY
      |-> ##2 o_protect_active == $past(o_protect_active, 2);
  endproperty
  a_bad_key: assert property (p_bad_key) else $error("bad key changed protect");
  property p_cfg_locked;
    wr_take && o_protect_active |-> ##2 cfg_all == $past(cfg_all, 2);
  endproperty
  a_cfg_locked: assert property (p_cfg_locked) else $error("locked config changed");
  property p_read_locked;
    i_s_axi_arvalid && o_s_axi_arready && i_s_axi_araddr == `USW_OFF_MODE && o_protect_active
      |=> o_s_axi_rdata == $past(o_mode);
  endproperty
  a_read_locked: assert property (p_read_locked) else $error("locked read wrong");
endmodule
bind usw_top usw_top_checker i_chk (.*);
`default_nettype wire

// ==== verilog/usw_cfg_reg.sv ====
// One write-protectable 32-bit configuration register
`timescale 1ns/1ps
`include "usw_regs.svh"
`default_nettype none
module usw_cfg_reg #(
  parameter logic [31:0] RESET_VALUE = `USW_CFG_RESET
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_reset,
  input  wire logic        i_write,
  input  wire logic        i_protect,
  input  wire logic [31:0] i_data,
  input  wire logic [3:0]  i_strb,
  output logic [31:0]      o_value
);
  // ****************************************************************************
  // Storage
  // ****************************************************************************
  // Protected write dropped silently, reads unaffected
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_value <= RESET_VALUE;
    end else if (i_write && !i_protect) begin
      for (int b = 0; b < 4; b++) begin
        if (i_strb[b]) begin
          o_value[8*b +: 8] <= i_data[8*b +: 8];
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== verilog/usw_pkg.sv ====
// Types shared by the status and protect block
`default_nettype none
package usw_pkg;
  // Modem control input group
  typedef struct packed {
    logic ri;
    logic dsr;
    logic dcd;
    logic cts;
  } usw_modem_s;

  // Bus write request as presented to the register core
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] data;
    logic [3:0]  strb;
  } usw_wreq_s;

  typedef enum logic [1:0] {USW_W_IDLE, USW_W_RESP} usw_wstate_e;
endpackage
`default_nettype wire

// ==== verilog/usw_regs.svh ====
// Register offsets, field positions, reset values and key for the status and protect block
`ifndef USW_REGS_SVH
`define USW_REGS_SVH
// ****************************************************************************
// Register byte offsets
// ****************************************************************************
`define USW_OFF_CONTROL      8'h00
`define USW_OFF_MODE         8'h04
`define USW_OFF_IRQ_MASK     8'h08
`define USW_OFF_CHAN_STATUS  8'h14
`define USW_OFF_BAUD         8'h20
`define USW_OFF_RX_TIMEOUT   8'h24
`define USW_OFF_TX_GUARD     8'h28
`define USW_OFF_FIDI         8'h40
`define USW_OFF_IR_FILTER    8'h4C
`define USW_OFF_MAN_CONFIG   8'h50
`define USW_OFF_WPROT        8'hE4
// ****************************************************************************
// Field positions
// ****************************************************************************
`define USW_CTRL_RST_STATUS_BIT 8
`define USW_CS_CTS_CHG_BIT   19
`define USW_CS_MAN_ERR_BIT   24
`define USW_CS_RI_BIT        20
`define USW_CS_DSR_BIT       21
`define USW_CS_DCD_BIT       22
`define USW_CS_CTS_BIT       23
`define USW_WP_EN_BIT        0
`define USW_WP_KEY_LSB       8
`define USW_WP_KEY_MSB       31
// ****************************************************************************
// Constants and reset values
// ****************************************************************************
`define USW_PROTECT_KEY      24'h55_5341
`define USW_CFG_RESET        32'h0000_0000
`define USW_IRQ_MASK_RESET   32'h0000_0000
`define USW_SLVERR           2'b10
`define USW_OKAY             2'b00
`endif

// ==== verilog/usw_sync.sv ====
// Two-flop synchroniser for one pin bit
`timescale 1ns/1ps
`default_nettype none
module usw_sync (
  input  wire logic i_clk_sys,
  input  wire logic i_reset,
  input  wire logic i_async,
  output logic      o_sync
);
  logic meta_reg;

  // ****************************************************************************
  // Synchroniser
  // ****************************************************************************
  // First stage feeds only the second stage
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      meta_reg <= 1'b0;
      o_sync   <= 1'b0;
    end else begin
      meta_reg <= i_async;
      o_sync   <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// ==== verilog/usw_top.sv ====
// Modem status flags, Manchester error flag and keyed configuration write protect
//
// Design decisions made here: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "usw_regs.svh"
`default_nettype none
module usw_top (
  input  wire logic             i_clk_sys,
  input  wire logic             i_reset,
  // AXI4-Lite slave
  input  wire logic [7:0]       i_s_axi_awaddr,
  input  wire logic             i_s_axi_awvalid,
  output logic                  o_s_axi_awready,
  input  wire logic [31:0]      i_s_axi_wdata,
  input  wire logic [3:0]       i_s_axi_wstrb,
  input  wire logic             i_s_axi_wvalid,
  output logic                  o_s_axi_wready,
  output logic [1:0]            o_s_axi_bresp,
  output logic                  o_s_axi_bvalid,
  input  wire logic             i_s_axi_bready,
  input  wire logic [7:0]       i_s_axi_araddr,
  input  wire logic             i_s_axi_arvalid,
  output logic                  o_s_axi_arready,
  output logic [31:0]           o_s_axi_rdata,
  output logic [1:0]            o_s_axi_rresp,
  output logic                  o_s_axi_rvalid,
  input  wire logic             i_s_axi_rready,
  // Modem pins and receiver event
  input  wire usw_pkg::usw_modem_s i_modem,
  input  wire logic             i_manchester_violation,
  // Outputs
  output logic                  o_irq,
  output logic                  o_protect_active,
  output logic [31:0]           o_mode,
  output logic [31:0]           o_baud,
  output logic [31:0]           o_rx_timeout,
  output logic [31:0]           o_tx_guard,
  output logic [31:0]           o_fidi,
  output logic [31:0]           o_ir_filter,
  output logic [31:0]           o_man_config
);
  // ****************************************************************************
  // Pin synchronisers
  // ****************************************************************************
  usw_pkg::usw_modem_s modem_sync;
  logic                cts_prev_reg;

  usw_sync u_sync_ri (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .i_async   (i_modem.ri),
    .o_sync    (modem_sync.ri)
  );
  usw_sync u_sync_dsr (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .i_async   (i_modem.dsr),
    .o_sync    (modem_sync.dsr)
  );
  usw_sync u_sync_dcd (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .i_async   (i_modem.dcd),
    .o_sync    (modem_sync.dcd)
  );
  usw_sync u_sync_cts (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .i_async   (i_modem.cts),
    .o_sync    (modem_sync.cts)
  );

  // Previous CTS level; armed once the sync chain holds real pin data
  logic [1:0] cts_fill_reg;
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      cts_prev_reg <= 1'b0;
      cts_fill_reg <= 2'h0;
    end else begin
      cts_prev_reg <= modem_sync.cts;
      if (cts_fill_reg != 2'h3) begin
        cts_fill_reg <= cts_fill_reg + 2'h1;
      end
    end
  end

  logic cts_edge;
  // edge on CTS
  // Reset zeros in the chain must not pose as an edge on an idle-high pin
  assign cts_edge = (cts_fill_reg == 2'h3) && (cts_prev_reg != modem_sync.cts);

  // ****************************************************************************
  // AXI4-Lite write path
  // ****************************************************************************
  logic        aw_held_reg;
  logic        w_held_reg;
  logic [7:0]  awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        wr_fire;
  logic        wr_hit;

  // Accept each channel once; hold until the response is taken
  assign o_s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign o_s_axi_wready  = !w_held_reg && !bvalid_reg;
  assign wr_fire         = aw_held_reg && w_held_reg && !bvalid_reg;

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      awaddr_reg  <= 8'h00;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
    end else begin
      if (i_s_axi_awvalid && o_s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= i_s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_reg <= 1'b0;
      end
      if (i_s_axi_wvalid && o_s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg  <= i_s_axi_wdata;
        wstrb_reg  <= i_s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  // Write decode; unmapped offsets answer SLVERR
  always_comb begin
    unique case ({awaddr_reg[7:2], 2'b00})
      `USW_OFF_CONTROL, `USW_OFF_MODE, `USW_OFF_IRQ_MASK, `USW_OFF_BAUD,
      `USW_OFF_RX_TIMEOUT, `USW_OFF_TX_GUARD, `USW_OFF_FIDI,
      `USW_OFF_IR_FILTER, `USW_OFF_MAN_CONFIG, `USW_OFF_WPROT: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= `USW_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_hit ? `USW_OKAY : `USW_SLVERR;
    end else if (i_s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end
  assign o_s_axi_bvalid = bvalid_reg;
  assign o_s_axi_bresp  = bresp_reg;

  logic wr_sel_word;
  logic [7:0] wr_off;
  assign wr_off      = {awaddr_reg[7:2], 2'b00};
  assign wr_sel_word = wr_fire && (wstrb_reg == 4'hF);

  // ****************************************************************************
  // Write protect register
  // ****************************************************************************
  logic protect_enable_reg;
  logic key_ok;
  assign key_ok = wdata_reg[`USW_WP_KEY_MSB:`USW_WP_KEY_LSB] == `USW_PROTECT_KEY;

  // keyed update
  // Needs all byte lanes so the key arrives whole
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      protect_enable_reg <= 1'b0;
    end else if (wr_sel_word && wr_off == `USW_OFF_WPROT && key_ok) begin
      protect_enable_reg <= wdata_reg[`USW_WP_EN_BIT];
    end
  end
  assign o_protect_active = protect_enable_reg;

  // ****************************************************************************
  // Protected configuration registers
  // ****************************************************************************
  logic [7:0]  cfg_off [7];
  logic [31:0] cfg_val [7];
  assign cfg_off[0] = `USW_OFF_MODE;
  assign cfg_off[1] = `USW_OFF_BAUD;
  assign cfg_off[2] = `USW_OFF_RX_TIMEOUT;
  assign cfg_off[3] = `USW_OFF_TX_GUARD;
  assign cfg_off[4] = `USW_OFF_FIDI;
  assign cfg_off[5] = `USW_OFF_IR_FILTER;
  assign cfg_off[6] = `USW_OFF_MAN_CONFIG;

  for (genvar g = 0; g < 7; g++) begin : g_cfg
    usw_cfg_reg #(
      .RESET_VALUE (`USW_CFG_RESET)
    ) u_cfg (
      .i_clk_sys (i_clk_sys),
      .i_reset   (i_reset),
      .i_write   (wr_fire && wr_off == cfg_off[g]),
      .i_protect (protect_enable_reg),
      .i_data    (wdata_reg),
      .i_strb    (wstrb_reg),
      .o_value   (cfg_val[g])
    );
  end
  assign o_mode       = cfg_val[0];
  assign o_baud       = cfg_val[1];
  assign o_rx_timeout = cfg_val[2];
  assign o_tx_guard   = cfg_val[3];
  assign o_fidi       = cfg_val[4];
  assign o_ir_filter  = cfg_val[5];
  assign o_man_config = cfg_val[6];

  // ****************************************************************************
  // Interrupt mask and control command
  // ****************************************************************************
  logic [31:0] irq_mask_reg;
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      irq_mask_reg <= `USW_IRQ_MASK_RESET;
    end else if (wr_fire && wr_off == `USW_OFF_IRQ_MASK) begin
      for (int b = 0; b < 4; b++) begin
        if (wstrb_reg[b]) begin
          irq_mask_reg[8*b +: 8] <= wdata_reg[8*b +: 8];
        end
      end
    end
  end

  logic reset_status_command;
  assign reset_status_command = wr_fire && wr_off == `USW_OFF_CONTROL
                                && wstrb_reg[1] && wdata_reg[`USW_CTRL_RST_STATUS_BIT];

  // ****************************************************************************
  // AXI4-Lite read path and status flags
  // ****************************************************************************
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  logic        rd_fire;
  logic [7:0]  rd_off;
  logic        cts_change_flag_reg;
  logic        manchester_error_flag_reg;
  logic        status_read;

  assign o_s_axi_arready = !rvalid_reg;
  assign rd_fire         = i_s_axi_arvalid && !rvalid_reg;
  assign rd_off          = {i_s_axi_araddr[7:2], 2'b00};
  assign status_read     = rd_fire && rd_off == `USW_OFF_CHAN_STATUS;

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      cts_change_flag_reg <= 1'b0;
    end else if (cts_edge) begin
      cts_change_flag_reg <= 1'b1;
    end else if (status_read) begin
      cts_change_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      manchester_error_flag_reg <= 1'b0;
    end else if (i_manchester_violation) begin
      manchester_error_flag_reg <= 1'b1;
    end else if (reset_status_command) begin
      manchester_error_flag_reg <= 1'b0;
    end
  end

  logic [31:0] status_word;
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`USW_CS_CTS_CHG_BIT] = cts_change_flag_reg;
    status_word[`USW_CS_RI_BIT]      = modem_sync.ri;
    status_word[`USW_CS_DSR_BIT]     = modem_sync.dsr;
    status_word[`USW_CS_DCD_BIT]     = modem_sync.dcd;
    status_word[`USW_CS_CTS_BIT]     = modem_sync.cts;
    status_word[`USW_CS_MAN_ERR_BIT] = manchester_error_flag_reg;
  end

  // Read mux; key field reads zero
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= `USW_OKAY;
    end else if (rd_fire) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= `USW_OKAY;
      unique case (rd_off)
        `USW_OFF_CONTROL:     rdata_reg <= 32'h0000_0000;
        `USW_OFF_MODE:        rdata_reg <= cfg_val[0];
        `USW_OFF_IRQ_MASK:    rdata_reg <= irq_mask_reg;
        `USW_OFF_CHAN_STATUS: rdata_reg <= status_word;
        `USW_OFF_BAUD:        rdata_reg <= cfg_val[1];
        `USW_OFF_RX_TIMEOUT:  rdata_reg <= cfg_val[2];
        `USW_OFF_TX_GUARD:    rdata_reg <= cfg_val[3];
        `USW_OFF_FIDI:        rdata_reg <= cfg_val[4];
        `USW_OFF_IR_FILTER:   rdata_reg <= cfg_val[5];
        `USW_OFF_MAN_CONFIG:  rdata_reg <= cfg_val[6];
        `USW_OFF_WPROT:       rdata_reg <= {31'h0000_0000, protect_enable_reg};
        default: begin
          rdata_reg <= 32'h0000_0000;
          rresp_reg <= `USW_SLVERR;
        end
      endcase
    end else if (i_s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end
  assign o_s_axi_rvalid = rvalid_reg;
  assign o_s_axi_rdata  = rdata_reg;
  assign o_s_axi_rresp  = rresp_reg;

  // ****************************************************************************
  // Interrupt
  // ****************************************************************************
  // Level while any unmasked sticky flag is set
  assign o_irq = |(irq_mask_reg & {7'h00, manchester_error_flag_reg, 4'h0,
                                   cts_change_flag_reg, 19'h0_0000});
endmodule
`default_nettype wire
